//--- rtl/pvc_pkg.sv
package pvc_pkg;
    // Percent quantities are signed 0.01 % steps of the input range
    localparam int PCT_FULL = 10000;
    localparam int PCT_HALF = 5000;
    localparam int CUT_MAX = 500;
    localparam int CUT_RST = 100;
    localparam int SEG_MIN = -500;
    localparam int SEG_MAX = 10500;
    localparam int SEG_N = 11;
    localparam int MEAS_LO = 0;
    localparam int MEAS_HI = 10000;
    localparam int PER_MIN = 1;
    localparam int PER_MAX = 120;
    localparam int PER_RELAY = 30;
    localparam int PER_SSR = 3;
    // Rate limit in 0.01 %/s steps, applied per ms tick, so 0.1 %/s is 10
    localparam int RATE_MIN = 10;
    localparam int RATE_MAX = 10000;
    localparam int ACC_SCALE = 1000;
    localparam int MS_PER_S = 1000;
    localparam int CLK_NS = 8;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int KEY_HOLD_S = 3;
    localparam int KEY_HOLD_MS = KEY_HOLD_S * MS_PER_S;
    localparam int ROOT_BITS = 14;
    localparam int DIV_BITS = 32;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CUT = 8'h04;
    localparam logic [7:0] A_RST = 8'h08;
    localparam logic [7:0] A_ERR = 8'h0C;
    localparam logic [7:0] A_PER1 = 8'h10;
    localparam logic [7:0] A_PER2 = 8'h14;
    localparam logic [7:0] A_RATE1 = 8'h18;
    localparam logic [7:0] A_RATE2 = 8'h1C;
    localparam logic [7:0] A_FLOOR = 8'h20;
    localparam logic [7:0] A_CEIL = 8'h24;
    localparam logic [7:0] A_SPFIX = 8'h28;
    localparam logic [7:0] A_SPSTART = 8'h2C;
    localparam logic [7:0] A_SPSTEP = 8'h30;
    localparam logic [7:0] A_PV = 8'h34;
    localparam logic [7:0] A_STAT = 8'h38;
    localparam logic [7:0] A_CSTAGE = 8'h3C;
    localparam logic [1:0] A_SEGIN = 2'h1;
    localparam logic [1:0] A_SEGOUT = 2'h2;
    localparam logic [2:0] A_COMP = 3'h6;
    typedef enum logic [1:0] {
        PVC_IDLE,
        PVC_ROOT,
        PVC_SEG,
        PVC_DIV
    } pvc_state_t;
endpackage : pvc_pkg

//--- rtl/pvc_core.sv
// Summary of operation
// - Square root only while sqrt enable on
// - Cutoff acts only with square root on
// - Input at or below cutoff gives zero
// - Cutoff 0.0 to 5.0 percent, default 1.0
// - Cutoff first, then square root
// - Reverse: output rises as PV drops below SV
// - Direct: output rises as PV exceeds SV
// - Reset state holds reset output level
// - Input error drives error output level
// - Reset level wins over error level
// - On-off: fixed level snaps to 0 or 100
// - Proportional period 1 to 120 s
// - Segment linearizer only when enabled
// - Eleven breakpoints, linear interpolation between
// - Output below previous input ends valid points
// - Breakpoints -5.0 to 105.0, default 0.0
// - Per-output rate limit, off or bounded
// - Floor below ceiling, inside measuring range
// - Stored setpoints clamped to floor and ceiling
// - Compensation only in reset, unlocked
// - Keys held 3 s; confirm stores count
// - Low and high counts per output
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module pvc_core #(
    parameter int TICK_CYCLES = pvc_pkg::TICK_CYC,
    parameter bit FIRST_OUTPUT_SSR = 1'b0,
    parameter bit SECOND_OUTPUT_SSR = 1'b1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] rawInput,
    input wire logic inputError,
    input wire logic ch1Reset,
    input wire logic ch2Reset,
    input wire logic keyLock,
    input wire logic confirmKey,
    input wire logic groupKey,
    output logic signed [15:0] processValue,
    output logic signed [15:0] setpointValue,
    output logic [15:0] firstOutput,
    output logic [15:0] secondOutput,
    output logic firstDrive,
    output logic secondDrive,
    output logic compActive
);
    if (TICK_CYCLES < 2 || TICK_CYCLES > 131071) begin : g_chk
        $error("TICK_CYCLES out of range");
    end

    typedef struct packed {
        logic sqrtEn;
        logic segEn;
        logic onoff;
        logic [1:0] dir;
        logic [15:0] cut;
        logic [15:0] rstLvl;
        logic [15:0] errLvl;
        logic [1:0][6:0] per;
        logic [1:0][15:0] rate;
        logic signed [15:0] spLo;
        logic signed [15:0] spHi;
        logic [2:0][15:0] sp;
        logic [10:0][15:0] segA;
        logic [10:0][15:0] segB;
        logic [7:0][15:0] comp;
        logic [2:0] cSel;
        logic [15:0] cVal;
        logic cOn;
        logic [11:0] keyCnt;
        logic confPrev;
        logic [16:0] tick;
        logic [1:0][16:0] msCnt;
        logic [1:0][23:0] acc;
        logic [1:0][15:0] lvl;
        logic [1:0] drive;
        pvc_pkg::pvc_state_t st;
        logic [4:0] bitIdx;
        logic [26:0] rad;
        logic [13:0] root;
        logic signed [16:0] x;
        logic [31:0] quo;
        logic [16:0] rem;
        logic [15:0] den;
        logic neg;
        logic signed [15:0] base;
        logic signed [15:0] pv;
        logic [31:0] rd;
    } pvc_regs_t;

    pvc_regs_t s_ff;
    pvc_regs_t nxt_s;

    function automatic logic signed [15:0] clampSp(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        clampSp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampSp

    logic signed [15:0] wv;
    logic signed [15:0] sv;
    logic [3:0] segI;
    logic isA;
    logic isB;
    logic isC;
    logic hit;
    logic ok;
    logic tickNow;
    logic compOk;
    logic [31:0] rdv;
    logic [3:0] nv;
    logic [3:0] k;
    logic signed [16:0] dx;
    logic signed [16:0] dy;
    logic signed [16:0] dd;
    logic signed [33:0] prod;
    logic [26:0] trial;
    logic [27:0] trySq;
    logic [17:0] remSh;
    logic signed [16:0] dev;
    logic [15:0] tgt;
    logic [15:0] fixLvl;
    logic [23:0] t1k;
    logic [16:0] perMs;
    logic chRst;

    always_comb begin
        nxt_s = s_ff;
        wv = $signed(pwdata[15:0]);
        segI = paddr[5:2];
        isA = (paddr[7:6] == pvc_pkg::A_SEGIN) && (segI < 4'd11);
        isB = (paddr[7:6] == pvc_pkg::A_SEGOUT) && (segI < 4'd11);
        isC = (paddr[7:5] == pvc_pkg::A_COMP);
        compOk = ch1Reset && ch2Reset && !keyLock;
        tickNow = (s_ff.tick == 17'(TICK_CYCLES - 1));
        nxt_s.tick = tickNow ? 17'h0 : s_ff.tick + 17'h1;
        sv = clampSp($signed(s_ff.sp[0]), s_ff.spLo, s_ff.spHi);

        // Register bus: data captured in setup, zero wait access
        hit = 1'b1;
        ok = 1'b1;
        rdv = 32'h0;
        if (isA) begin
            rdv = {{16{s_ff.segA[segI][15]}}, s_ff.segA[segI]};
            ok = wv >= 16'(pvc_pkg::SEG_MIN) && wv <= 16'(pvc_pkg::SEG_MAX);
        end else if (isB) begin
            rdv = {{16{s_ff.segB[segI][15]}}, s_ff.segB[segI]};
            ok = wv >= 16'(pvc_pkg::SEG_MIN) && wv <= 16'(pvc_pkg::SEG_MAX);
        end else if (isC) begin
            rdv = {16'h0, s_ff.comp[paddr[4:2]]};
            ok = 1'b0;
        end else begin
            case (paddr)
                pvc_pkg::A_CTRL: begin
                    rdv = {27'h0, s_ff.dir, s_ff.onoff, s_ff.segEn, s_ff.sqrtEn};
                end
                pvc_pkg::A_CUT: begin
                    rdv = {16'h0, s_ff.cut};
                    ok = wv >= 0 && wv <= 16'(pvc_pkg::CUT_MAX);
                end
                pvc_pkg::A_RST, pvc_pkg::A_ERR: begin
                    rdv = {16'h0, paddr[2] ? s_ff.errLvl : s_ff.rstLvl};
                    ok = wv >= 0 && wv <= 16'(pvc_pkg::PCT_FULL);
                end
                pvc_pkg::A_PER1, pvc_pkg::A_PER2: begin
                    rdv = {25'h0, s_ff.per[paddr[2]]};
                    ok = wv >= 16'(pvc_pkg::PER_MIN)
                        && wv <= 16'(pvc_pkg::PER_MAX);
                end
                pvc_pkg::A_RATE1, pvc_pkg::A_RATE2: begin
                    rdv = {16'h0, s_ff.rate[paddr[2]]};
                    ok = wv == 0 || (wv >= 16'(pvc_pkg::RATE_MIN)
                        && wv <= 16'(pvc_pkg::RATE_MAX));
                end
                pvc_pkg::A_FLOOR: begin
                    rdv = {{16{s_ff.spLo[15]}}, s_ff.spLo};
                    ok = wv >= 16'(pvc_pkg::MEAS_LO) && wv < s_ff.spHi;
                end
                pvc_pkg::A_CEIL: begin
                    rdv = {{16{s_ff.spHi[15]}}, s_ff.spHi};
                    ok = wv > s_ff.spLo && wv <= 16'(pvc_pkg::MEAS_HI);
                end
                pvc_pkg::A_SPFIX, pvc_pkg::A_SPSTART, pvc_pkg::A_SPSTEP: begin
                    rdv = 32'(clampSp($signed(s_ff.sp[2'((paddr - 8'h28) >> 2)]),
                        s_ff.spLo, s_ff.spHi));
                end
                pvc_pkg::A_PV: begin
                    rdv = {{16{s_ff.pv[15]}}, s_ff.pv};
                    ok = 1'b0;
                end
                pvc_pkg::A_STAT: begin
                    rdv = {29'h0, s_ff.cOn, s_ff.drive};
                    ok = 1'b0;
                end
                pvc_pkg::A_CSTAGE: begin
                    rdv = {13'h0, s_ff.cSel, s_ff.cVal};
                end
                default: begin
                    hit = 1'b0;
                    ok = 1'b0;
                end
            endcase
        end
        pready = 1'b1;
        pslverr = psel && penable && (!hit || (pwrite && !ok));
        if (psel && !penable) begin
            nxt_s.rd = hit ? rdv : 32'h0;
        end
        if (psel && penable && pwrite && ok) begin
            if (isA) begin
                nxt_s.segA[segI] = pwdata[15:0];
            end else if (isB) begin
                nxt_s.segB[segI] = pwdata[15:0];
            end else begin
                case (paddr)
                    pvc_pkg::A_CTRL: begin
                        {nxt_s.dir, nxt_s.onoff, nxt_s.segEn, nxt_s.sqrtEn} =
                            pwdata[4:0];
                    end
                    pvc_pkg::A_CUT: nxt_s.cut = pwdata[15:0];
                    pvc_pkg::A_RST: nxt_s.rstLvl = pwdata[15:0];
                    pvc_pkg::A_ERR: nxt_s.errLvl = pwdata[15:0];
                    pvc_pkg::A_PER1: nxt_s.per[0] = pwdata[6:0];
                    pvc_pkg::A_PER2: nxt_s.per[1] = pwdata[6:0];
                    pvc_pkg::A_RATE1: nxt_s.rate[0] = pwdata[15:0];
                    pvc_pkg::A_RATE2: nxt_s.rate[1] = pwdata[15:0];
                    pvc_pkg::A_FLOOR: nxt_s.spLo = wv;
                    pvc_pkg::A_CEIL: nxt_s.spHi = wv;
                    pvc_pkg::A_SPFIX: nxt_s.sp[0] = pwdata[15:0];
                    pvc_pkg::A_SPSTART: nxt_s.sp[1] = pwdata[15:0];
                    pvc_pkg::A_SPSTEP: nxt_s.sp[2] = pwdata[15:0];
                    pvc_pkg::A_CSTAGE: begin
                        nxt_s.cSel = pwdata[18:16];
                        nxt_s.cVal = pwdata[15:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Compensation entry: both keys held for the full time
        nxt_s.confPrev = confirmKey;
        if (!compOk) begin
            nxt_s.cOn = 1'b0;
            nxt_s.keyCnt = 12'h0;
        end else if (!(confirmKey && groupKey)) begin
            nxt_s.keyCnt = 12'h0;
        end else if (tickNow && !s_ff.cOn) begin
            nxt_s.keyCnt = s_ff.keyCnt + 12'h1;
            if (s_ff.keyCnt == 12'(pvc_pkg::KEY_HOLD_MS - 1)) begin
                nxt_s.cOn = 1'b1;
            end
        end
        if (s_ff.cOn && compOk && confirmKey && !s_ff.confPrev && !groupKey) begin
            nxt_s.comp[s_ff.cSel] = s_ff.cVal;
        end

        // Process value: cutoff, root, then linearizer
        nv = 4'd11;
        for (int i = 1; i < pvc_pkg::SEG_N; i++) begin
            if (nv == 4'd11 && $signed(s_ff.segB[i]) < $signed(s_ff.segA[i-1])) begin
                nv = 4'(i);
            end
        end
        k = 4'd0;
        for (int i = 1; i < pvc_pkg::SEG_N - 1; i++) begin
            if (4'(i) + 4'd1 < nv && s_ff.x >= $signed(s_ff.segA[i])) begin
                k = 4'(i);
            end
        end
        dx = s_ff.x - 17'($signed(s_ff.segA[k]));
        dy = 17'($signed(s_ff.segB[k + 4'd1])) - 17'($signed(s_ff.segB[k]));
        dd = 17'($signed(s_ff.segA[k + 4'd1])) - 17'($signed(s_ff.segA[k]));
        prod = dx * dy;
        trial = {13'h0, s_ff.root | 14'(1 << s_ff.bitIdx)};
        trySq = {1'b0, trial} * {1'b0, trial};
        remSh = {s_ff.rem, s_ff.quo[31]};
        case (s_ff.st)
            pvc_pkg::PVC_IDLE: begin
                nxt_s.x = 17'(rawInput);
                nxt_s.root = 14'h0;
                nxt_s.bitIdx = 5'(pvc_pkg::ROOT_BITS - 1);
                nxt_s.st = pvc_pkg::PVC_SEG;
                if (s_ff.sqrtEn) begin
                    nxt_s.st = pvc_pkg::PVC_ROOT;
                    if (rawInput <= $signed(s_ff.cut)) begin
                        nxt_s.rad = 27'h0;
                    end else begin
                        nxt_s.rad = 27'(rawInput * pvc_pkg::PCT_FULL);
                    end
                end
            end
            pvc_pkg::PVC_ROOT: begin
                if ({1'b0, trySq} <= {2'b0, s_ff.rad}) begin
                    nxt_s.root = trial[13:0];
                end
                if (s_ff.bitIdx == 5'h0) begin
                    nxt_s.x = 17'({1'b0, nxt_s.root});
                    nxt_s.st = pvc_pkg::PVC_SEG;
                end else begin
                    nxt_s.bitIdx = s_ff.bitIdx - 5'h1;
                end
            end
            pvc_pkg::PVC_SEG: begin
                nxt_s.st = pvc_pkg::PVC_IDLE;
                if (!s_ff.segEn) begin
                    nxt_s.pv = 16'(s_ff.x);
                end else if (nv < 4'd2 || dd <= 0) begin
                    nxt_s.pv = $signed(s_ff.segB[k]);
                end else begin
                    nxt_s.base = $signed(s_ff.segB[k]);
                    nxt_s.neg = prod[33];
                    nxt_s.quo = 32'(prod[33] ? -prod : prod);
                    nxt_s.den = 16'(dd);
                    nxt_s.rem = 17'h0;
                    nxt_s.bitIdx = 5'(pvc_pkg::DIV_BITS - 1);
                    nxt_s.st = pvc_pkg::PVC_DIV;
                end
            end
            pvc_pkg::PVC_DIV: begin
                nxt_s.quo = {s_ff.quo[30:0], 1'b0};
                nxt_s.rem = remSh[16:0];
                if (remSh >= {2'b0, s_ff.den}) begin
                    nxt_s.rem = 17'(remSh - {2'b0, s_ff.den});
                    nxt_s.quo[0] = 1'b1;
                end
                if (s_ff.bitIdx == 5'h0) begin
                    nxt_s.pv = s_ff.base + (s_ff.neg ? -16'(nxt_s.quo)
                        : 16'(nxt_s.quo));
                    nxt_s.st = pvc_pkg::PVC_IDLE;
                end else begin
                    nxt_s.bitIdx = s_ff.bitIdx - 5'h1;
                end
            end
            default: nxt_s.st = pvc_pkg::PVC_IDLE;
        endcase

        // Output conditioning per output
        dev = 17'sh0;
        tgt = 16'h0;
        fixLvl = 16'h0;
        t1k = 24'h0;
        perMs = 17'h0;
        chRst = 1'b0;
        for (int c = 0; c < 2; c++) begin
            chRst = (c == 0) ? ch1Reset : ch2Reset;
            dev = s_ff.dir[c] ? 17'(s_ff.pv) - 17'(sv)
                : 17'(sv) - 17'(s_ff.pv);
            if (s_ff.onoff) begin
                tgt = (dev > 0) ? 16'(pvc_pkg::PCT_FULL) : 16'h0;
            end else if (dev < 0) begin
                tgt = 16'h0;
            end else if (dev > 17'(pvc_pkg::PCT_FULL)) begin
                tgt = 16'(pvc_pkg::PCT_FULL);
            end else begin
                tgt = 16'(dev);
            end
            if (chRst || inputError) begin
                fixLvl = chRst ? s_ff.rstLvl : s_ff.errLvl;
                if (s_ff.onoff) begin
                    fixLvl = (fixLvl >= 16'(pvc_pkg::PCT_HALF))
                        ? 16'(pvc_pkg::PCT_FULL) : 16'h0;
                end
                tgt = fixLvl;
            end
            t1k = 24'(tgt * pvc_pkg::ACC_SCALE);
            // Stepping only once per ms keeps the slope exact in 0.00001 %
            if (s_ff.rate[c] == 16'h0) begin
                nxt_s.acc[c] = t1k;
            end else if (tickNow) begin
                if (s_ff.acc[c] + 24'(s_ff.rate[c]) < t1k) begin
                    nxt_s.acc[c] = s_ff.acc[c] + 24'(s_ff.rate[c]);
                end else if (s_ff.acc[c] > t1k + 24'(s_ff.rate[c])) begin
                    nxt_s.acc[c] = s_ff.acc[c] - 24'(s_ff.rate[c]);
                end else begin
                    nxt_s.acc[c] = t1k;
                end
            end
            nxt_s.lvl[c] = 16'(nxt_s.acc[c] / 24'(pvc_pkg::ACC_SCALE));
            perMs = 17'(s_ff.per[c] * pvc_pkg::MS_PER_S);
            if (tickNow) begin
                nxt_s.msCnt[c] = (s_ff.msCnt[c] >= perMs - 17'h1) ? 17'h0
                    : s_ff.msCnt[c] + 17'h1;
            end
            nxt_s.drive[c] = 32'(nxt_s.msCnt[c] * pvc_pkg::PCT_FULL)
                < 32'(nxt_s.lvl[c]) * 32'(perMs);
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_ff <= '0;
            s_ff.cut <= 16'(pvc_pkg::CUT_RST);
            s_ff.per[0] <= FIRST_OUTPUT_SSR ? 7'(pvc_pkg::PER_SSR)
                : 7'(pvc_pkg::PER_RELAY);
            s_ff.per[1] <= SECOND_OUTPUT_SSR ? 7'(pvc_pkg::PER_SSR)
                : 7'(pvc_pkg::PER_RELAY);
            s_ff.spLo <= 16'(pvc_pkg::MEAS_LO);
            s_ff.spHi <= 16'(pvc_pkg::MEAS_HI);
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata = s_ff.rd;
    assign processValue = s_ff.pv;
    assign setpointValue = sv;
    assign firstOutput = s_ff.lvl[0];
    assign secondOutput = s_ff.lvl[1];
    assign firstDrive = s_ff.drive[0];
    assign secondDrive = s_ff.drive[1];
    assign compActive = s_ff.cOn;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    cut_zero_a: assert property (
        s_ff.st == pvc_pkg::PVC_IDLE && s_ff.sqrtEn
        && rawInput <= $signed(s_ff.cut) |=> s_ff.rad == 27'h0)
        else $error("cutoff did not zero the input");
    no_root_a: assert property (
        s_ff.st == pvc_pkg::PVC_IDLE && !s_ff.sqrtEn
        |=> s_ff.st == pvc_pkg::PVC_SEG && s_ff.x == 17'($past(rawInput)))
        else $error("input altered with root off");
    root_ok_a: assert property (
        s_ff.st == pvc_pkg::PVC_ROOT && s_ff.bitIdx == 5'h0
        |=> 28'(s_ff.x) * 28'(s_ff.x) <= {1'b0, s_ff.rad}
        && 28'((s_ff.x + 1) * (s_ff.x + 1)) > {1'b0, s_ff.rad})
        else $error("square root wrong");
    cut_range_a: assert property (
        s_ff.cut <= 16'(pvc_pkg::CUT_MAX))
        else $error("cutoff out of range");
    rst_prio_a: assert property (
        ch1Reset && !s_ff.onoff && s_ff.rate[0] == 16'h0
        |=> firstOutput == $past(s_ff.rstLvl))
        else $error("reset level not output");
    err_out_a: assert property (
        !ch1Reset && inputError && !s_ff.onoff && s_ff.rate[0] == 16'h0
        |=> firstOutput == $past(s_ff.errLvl))
        else $error("error level not output");
    onoff_a: assert property (
        s_ff.onoff && s_ff.rate[0] == 16'h0 |=> firstOutput == 16'h0
        || firstOutput == 16'(pvc_pkg::PCT_FULL))
        else $error("on-off output not snapped");
    rate_step_a: assert property (
        $past(s_ff.rate[0]) != 16'h0 && s_ff.rate[0] == $past(s_ff.rate[0])
        |-> s_ff.acc[0] <= $past(s_ff.acc[0]) + 24'(s_ff.rate[0])
        && s_ff.acc[0] + 24'(s_ff.rate[0]) >= $past(s_ff.acc[0]))
        else $error("rate limit exceeded");
    lim_order_a: assert property (
        s_ff.spLo < s_ff.spHi)
        else $error("floor not below ceiling");
    sp_clamp_a: assert property (
        setpointValue >= s_ff.spLo && setpointValue <= s_ff.spHi)
        else $error("setpoint outside limits");
    comp_guard_a: assert property (
        compActive |-> $past(ch1Reset && ch2Reset && !keyLock))
        else $error("compensation while running");
    drive_off_a: assert property (
        firstOutput == 16'h0 |-> !firstDrive)
        else $error("drive on at zero level");
endmodule : pvc_core

//--- bench/pvc_sensor.sv
`timescale 1ns/1ps
// Sensor path: holds the level it was given, reports a broken input
module pvc_sensor (
    input wire logic clock,
    input wire logic signed [15:0] level,
    input wire logic fault,
    output logic signed [15:0] rawInput,
    output logic inputError
);
    always_ff @(posedge clock) begin
        rawInput <= level;
        inputError <= fault;
    end
endmodule : pvc_sensor

//--- bench/pv_linearize_output_condition_test.sv
`timescale 1ns/1ps
module pv_linearize_output_condition_test;
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, serr, inputError, fault = 0;
    logic ch1Reset = 0, ch2Reset = 0, keyLock = 0, confirmKey = 0;
    logic groupKey = 0;
    logic signed [15:0] rawInput, level = 16'h0, processValue, setpointValue;
    logic [15:0] firstOutput, secondOutput;
    logic firstDrive, secondDrive, compActive;
    int errTotal = 0, checkCount = 0, cyc = 0, hi;
    // Row: ctrl, raw level, error, reset, expected PV, expected output 1
    logic [15:0] rows [10][6] = '{
        '{16'h0, 16'd4000, 16'h0, 16'h0, 16'd4000, 16'd2000},
        '{16'h8, 16'd8000, 16'h0, 16'h0, 16'd8000, 16'd2000},
        '{16'h0, 16'd50, 16'h0, 16'h0, 16'd50, 16'd5950},
        '{16'h1, 16'd50, 16'h0, 16'h0, 16'd0, 16'd6000},
        '{16'h1, 16'd100, 16'h0, 16'h0, 16'd0, 16'd6000},
        '{16'h1, 16'd2500, 16'h0, 16'h0, 16'd5000, 16'd1000},
        '{16'h2, 16'd4000, 16'h0, 16'h0, 16'd2000, 16'd4000},
        '{16'h0, 16'd4000, 16'h1, 16'h0, 16'd4000, 16'd7000},
        '{16'h0, 16'd4000, 16'h1, 16'h1, 16'd4000, 16'd2500},
        '{16'h4, 16'd4000, 16'h0, 16'h1, 16'd4000, 16'd0}};
    always #4 clock = ~clock;
    pvc_sensor sens (.clock(clock), .level(level), .fault(fault),
        .rawInput(rawInput), .inputError(inputError));
    pvc_core #(.TICK_CYCLES(4)) uut (.clock(clock), .reset_n(reset_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rawInput(rawInput), .inputError(inputError),
        .ch1Reset(ch1Reset), .ch2Reset(ch2Reset), .keyLock(keyLock),
        .confirmKey(confirmKey), .groupKey(groupKey),
        .processValue(processValue),
        .setpointValue(setpointValue), .firstOutput(firstOutput),
        .secondOutput(secondOutput), .firstDrive(firstDrive),
        .secondDrive(secondDrive), .compActive(compActive));
    task summarize;
        $display("mismatches %0d comparisons %0d", errTotal, checkCount);
        if (errTotal == 0 && checkCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errTotal = errTotal + 1;
            summarize();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount = checkCount + 1;
        if (got !== exp) begin
            errTotal = errTotal + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until pready is seen high at a falling edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Answer is read while it stands before the edge that ends it
        do begin
            @(negedge clock);
            rdy = pready;
            rdat = prdata;
            serr = pslverr;
            @(posedge clock);
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock);
    endtask : apb
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        apb(0, pvc_pkg::A_CUT, 0);
        chk(rdat, 32'h64);
        apb(0, pvc_pkg::A_PER1, 0);
        chk(rdat, 32'h1E);
        apb(0, pvc_pkg::A_PER2, 0);
        chk(rdat, 32'h3);
        apb(1, pvc_pkg::A_CUT, 32'h1F5);
        chk(serr, 1'b1);
        apb(1, pvc_pkg::A_SPFIX, 32'h1770);
        apb(1, pvc_pkg::A_RST, 32'h9C4);
        apb(1, pvc_pkg::A_ERR, 32'h1B58);
        // Two valid breakpoints: the third output lies below A1
        apb(1, 8'h44, 32'h2710);
        apb(1, 8'h84, 32'h1388);
        apb(1, 8'h48, 32'h2905);
        chk(serr, 1'b1);
        for (int i = 0; i < 10; i++) begin
            apb(1, pvc_pkg::A_CTRL, 32'(rows[i][0]));
            @(posedge clock);
            level <= rows[i][1];
            fault <= rows[i][2][0];
            ch1Reset <= rows[i][3][0];
            // A divide pass is 34 cycles; a stale pass may finish first
            repeat (100) @(negedge clock);
            chk(processValue, rows[i][4]);
            chk(firstOutput, rows[i][5]);
        end
        chk(secondOutput, 16'd10000);
        apb(1, pvc_pkg::A_CTRL, 32'h0);
        apb(1, pvc_pkg::A_CEIL, 32'h1388);
        chk(setpointValue, 16'd5000);
        apb(1, pvc_pkg::A_FLOOR, 32'h1388);
        chk(serr, 1'b1);
        apb(1, pvc_pkg::A_PV, 32'h0);
        chk(serr, 1'b1);
        apb(1, pvc_pkg::A_PER1, 32'h1);
        hi = 0;
        // One full 1 s period at 4 cycles per tick, any phase
        repeat (8000) @(posedge clock);
        repeat (4000) begin
            @(negedge clock);
            if (firstDrive === 1'b1) hi = hi + 1;
        end
        chk(hi, 1000);
        apb(1, pvc_pkg::A_RATE1, 32'h2710);
        apb(1, pvc_pkg::A_RST, 32'h1388);
        // 10 units per 4-cycle tick, from 2500 up to 5000
        repeat (400) @(negedge clock);
        chk(firstOutput > 16'd3400 && firstOutput < 16'd3600, 1'b1);
        repeat (1000) @(negedge clock);
        chk(firstOutput, 16'd5000);
        @(posedge clock);
        ch2Reset <= 1'b1;
        confirmKey <= 1'b1;
        groupKey <= 1'b1;
        // Hold time is 3000 ticks of 4 cycles
        repeat (11900) @(negedge clock);
        chk(compActive, 1'b0);
        repeat (200) @(negedge clock);
        chk(compActive, 1'b1);
        @(posedge clock);
        confirmKey <= 1'b0;
        groupKey <= 1'b0;
        apb(1, pvc_pkg::A_CSTAGE, 32'h11234);
        @(posedge clock);
        confirmKey <= 1'b1;
        apb(0, 8'hC4, 32'h0);
        chk(rdat, 32'h1234);
        @(posedge clock);
        ch2Reset <= 1'b0;
        repeat (2) @(negedge clock);
        chk(compActive, 1'b0);
        summarize();
    end
endmodule : pv_linearize_output_condition_test
